/* File: core/pbo_pin_ctl.sv */
`timescale 1ns/1ps
module pbo_pin_ctl
(
	input wire pbo_pkg::pbo_ovr_t ovr,
	input wire logic dir,
	input wire logic latch,
	input wire logic pull_off,
	input wire logic sleep_active,
	output logic oe,
	output logic value,
	output logic pull_en,
	output logic din_en
);

	////////////////////////////////////////////////////////////////////////
	// Generic override application for one pin
	always_comb
	begin
		// Pull-up: override value, else input with latch high and not disabled
		if (ovr.pullup_ovr_en)
		begin
			pull_en = ovr.pullup_ovr_val;
		end
		else
		begin
			pull_en = ~dir & latch & ~pull_off;
		end
		// Output driver enable
		if (ovr.dir_ovr_en)
		begin
			oe = ovr.dir_ovr_val;
		end
		else
		begin
			oe = dir;
		end
		// Driven value
		if (ovr.value_ovr_en)
		begin
			value = ovr.value_ovr_val;
		end
		else
		begin
			value = latch;
		end
		// Digital input enable
		if (ovr.din_enable_ovr_en)
		begin
			din_en = ovr.din_enable_ovr_val;
		end
		else
		begin
			din_en = ~sleep_active;
		end
	end

endmodule : pbo_pin_ctl

/* File: core/pbo_pkg.sv */
package pbo_pkg;

	// Port width
	localparam int PBO_WIDTH = 8;

	// Pin positions of the alternate functions
	localparam int PBO_BIT_CAPTURE = 0;
	localparam int PBO_BIT_CMP_1A = 1;
	localparam int PBO_BIT_SELECT = 2;
	localparam int PBO_BIT_MOSI = 3;
	localparam int PBO_BIT_MISO = 4;
	localparam int PBO_BIT_SCK = 5;
	localparam int PBO_BIT_OSC1 = 6;
	localparam int PBO_BIT_OSC2 = 7;

	// Reset values of the registered pad controls and the pin synchroniser
	localparam logic [7:0] PBO_PAD_OUT_RST = 8'h00;
	localparam logic [7:0] PBO_PAD_OE_RST = 8'h00;
	localparam logic [7:0] PBO_PULLUP_RST = 8'h00;
	localparam logic [7:0] PBO_DIN_EN_RST = 8'h00;
	localparam logic [7:0] PBO_SYNC_RST = 8'h00;

	// Clock select fuse codes
	localparam int PBO_CLK_SEL_W = 4;
	localparam logic [3:0] PBO_CLK_SEL_EXT = 4'h0;
	localparam logic [3:0] PBO_CLK_SEL_RC_CAL = 4'h2;
	localparam logic [3:0] PBO_CLK_SEL_RC_LOW = 4'h3;

	// Override bundle for one pin
	typedef struct packed {
		logic pullup_ovr_en;
		logic pullup_ovr_val;
		logic dir_ovr_en;
		logic dir_ovr_val;
		logic value_ovr_en;
		logic value_ovr_val;
		logic din_enable_ovr_en;
		logic din_enable_ovr_val;
	} pbo_ovr_t;

	// First serial-peripheral engine controls and outputs
	typedef struct packed {
		logic enable;
		logic master;
		logic clock_out;
		logic master_out;
		logic slave_out;
	} pbo_spi_t;

	// Timer compare outputs, index 0 = 16-bit A, 1 = 16-bit B, 2 = 8-bit A
	typedef struct packed {
		logic [2:0] cmp_en;
		logic [2:0] cmp_out;
	} pbo_tmr_t;

	// Inputs handed to the peripherals
	typedef struct packed {
		logic spi_a_clock_in;
		logic spi_a_master_in;
		logic spi_a_slave_in;
		logic spi_a_select_active;
		logic usart_a_clock_in;
		logic usart_b_rx_pin;
		logic timer16_capture_in;
	} pbo_periph_in_t;

endpackage : pbo_pkg

/* File: core/pbo_port_b_ovr.sv */
// Function
// - Oscillator bit 6 reads dir, latch, pin zero
// - Slave SPI forces clock pin input
// - SPI- and USART-B-forced inputs keep latch-controlled pull-up
// - Sync USART clock direction follows pb_dir5
// - Master SPI forces master-in pin input
// - USART-B receiver forces bit 4 input
// - Slave SPI forces master-out pin input unless the USART-B transmitter is enabled
// - USART-B transmitter forces bit 3 output
// - Compare outputs reach pin only when output
// - Slave SPI select input, active low
// - Clock-out fuse drives bit 0, even reset
// - Bit 0 feeds 16-bit timer capture
// - Every bit feeds its pin-change source
// - Bit 7 digital-input override enable terms
// - Bit 6 digital-input override enable terms
// - SPI data lines split master/slave paths
// - Clock-select fuses decode internal RC, external
// - Pull-up follows override or normal combination
// - Driver follows direction override or bit
// - Pin value follows override or latch
// - Input enable follows override or sleep
`timescale 1ns/1ps
module pbo_port_b_ovr
#(
	parameter int WIDTH = pbo_pkg::PBO_WIDTH
)
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] pad_in,
	output logic [WIDTH-1:0] pad_out,
	output logic [WIDTH-1:0] pad_oe,
	output logic [WIDTH-1:0] pad_pullup,
	output logic [WIDTH-1:0] pad_din_en,
	input wire logic [WIDTH-1:0] pb_dir,
	input wire logic [WIDTH-1:0] pb_latch,
	output logic [WIDTH-1:0] pb_dir_rd,
	output logic [WIDTH-1:0] pb_latch_rd,
	output logic [WIDTH-1:0] pb_pinread,
	input wire logic pullup_global_disable,
	input wire logic sleep_active,
	input wire pbo_pkg::pbo_spi_t spi_a,
	input wire logic usart_a_sync_mode,
	input wire logic usart_a_sync_clock,
	input wire logic usart_b_rx_enable,
	input wire logic usart_b_tx_enable,
	input wire logic usart_b_tx_pin,
	input wire pbo_pkg::pbo_tmr_t timers,
	input wire logic clock_out_fuse,
	input wire logic divided_clock_out,
	input wire logic [pbo_pkg::PBO_CLK_SEL_W-1:0] clock_select_fuses,
	input wire logic async_timer_clocking,
	input wire logic pin_change_group_enable,
	input wire logic [WIDTH-1:0] pin_change_mask,
	output pbo_pkg::pbo_periph_in_t periph_in,
	output logic [WIDTH-1:0] pin_change_src,
	output logic internal_rc_selected,
	output logic external_clock_selected
);

	////////////////////////////////////////////////////////////////////////
	// Declarations
	pbo_pkg::pbo_ovr_t ovr [WIDTH];
	logic [WIDTH-1:0] sync1_q;
	logic [WIDTH-1:0] sync1_d;
	logic [WIDTH-1:0] sync2_q;
	logic [WIDTH-1:0] sync2_d;
	logic [WIDTH-1:0] oe_d;
	logic [WIDTH-1:0] oe_q;
	logic [WIDTH-1:0] out_d;
	logic [WIDTH-1:0] out_q;
	logic [WIDTH-1:0] pullup_d;
	logic [WIDTH-1:0] pullup_q;
	logic [WIDTH-1:0] din_en_d;
	logic [WIDTH-1:0] din_en_q;
	logic [WIDTH-1:0] ctl_oe;
	logic [WIDTH-1:0] ctl_out;
	logic [WIDTH-1:0] ctl_pull;
	logic [WIDTH-1:0] ctl_din;
	logic [WIDTH-1:0] pcint_ovr;
	logic [WIDTH-1:0] osc_pin;
	logic spi_slave;
	logic spi_master;
	logic osc7_use;
	logic osc6_use;
	logic sync_clk_drive;

	////////////////////////////////////////////////////////////////////////
	// Helpers
	// Pull-up value for a pin a peripheral forced to input
	function automatic logic forced_pullup(input logic latch, input logic pull_off);
		forced_pullup = latch & ~pull_off;
	endfunction : forced_pullup

	// Any internal RC code
	function automatic logic is_internal_rc(input logic [3:0] fuses);
		is_internal_rc = (fuses == pbo_pkg::PBO_CLK_SEL_RC_CAL)
			|| (fuses == pbo_pkg::PBO_CLK_SEL_RC_LOW);
	endfunction : is_internal_rc

	////////////////////////////////////////////////////////////////////////
	// Clock source decode
	always_comb
	begin
		internal_rc_selected = is_internal_rc(clock_select_fuses);
		external_clock_selected = (clock_select_fuses == pbo_pkg::PBO_CLK_SEL_EXT);
		// Oscillator use of bits 7 and 6
		osc7_use = (internal_rc_selected & external_clock_selected) | async_timer_clocking;
		osc6_use = internal_rc_selected | async_timer_clocking;
	end

	// Engine role terms
	assign spi_slave = spi_a.enable & ~spi_a.master;
	assign spi_master = spi_a.enable & spi_a.master;
	assign sync_clk_drive = usart_a_sync_mode & pb_dir[pbo_pkg::PBO_BIT_SCK];

	// Pin-change enable for the input overrides
	assign pcint_ovr = pin_change_mask & {WIDTH{pin_change_group_enable}};

	////////////////////////////////////////////////////////////////////////
	// Per-pin override tables
	always_comb
	begin
		// Defaults: nothing forced, pin-change keeps the input alive
		for (int i = 0; i < WIDTH; i++)
		begin
			ovr[i] = '0;
			ovr[i].din_enable_ovr_en = pcint_ovr[i];
			ovr[i].din_enable_ovr_val = 1'b1;
		end

		// Bit 7, second oscillator pin
		ovr[7].pullup_ovr_en = osc7_use;
		ovr[7].dir_ovr_en = osc7_use;
		ovr[7].din_enable_ovr_en = osc7_use | pcint_ovr[7];
		ovr[7].din_enable_ovr_val = (internal_rc_selected | external_clock_selected)
			& ~async_timer_clocking;

		// Bit 6, first oscillator pin
		ovr[6].pullup_ovr_en = osc6_use;
		ovr[6].dir_ovr_en = osc6_use;
		ovr[6].din_enable_ovr_en = osc6_use | pcint_ovr[6];
		ovr[6].din_enable_ovr_val = internal_rc_selected & async_timer_clocking;

		// Bit 5, SPI clock or synchronous USART clock
		ovr[5].dir_ovr_en = spi_slave;
		ovr[5].dir_ovr_val = 1'b0;
		ovr[5].pullup_ovr_en = spi_slave;
		ovr[5].pullup_ovr_val = forced_pullup(pb_latch[5], pullup_global_disable);
		ovr[5].value_ovr_en = spi_master | sync_clk_drive;
		if (spi_master)
		begin
			ovr[5].value_ovr_val = spi_a.clock_out;
		end
		else
		begin
			ovr[5].value_ovr_val = usart_a_sync_clock;
		end

		// Bit 4, SPI master-in / slave-out or USART-B receive
		ovr[4].dir_ovr_en = spi_master | usart_b_rx_enable;
		ovr[4].dir_ovr_val = 1'b0;
		ovr[4].pullup_ovr_en = spi_master | usart_b_rx_enable;
		ovr[4].pullup_ovr_val = forced_pullup(pb_latch[4], pullup_global_disable);
		ovr[4].value_ovr_en = spi_slave & ~usart_b_rx_enable;
		ovr[4].value_ovr_val = spi_a.slave_out;

		// Bit 3, SPI master-out / slave-in, USART-B transmit, 8-bit compare
		ovr[3].dir_ovr_en = spi_slave | usart_b_tx_enable;
		ovr[3].dir_ovr_val = usart_b_tx_enable;
		ovr[3].pullup_ovr_en = spi_slave & ~usart_b_tx_enable;
		ovr[3].pullup_ovr_val = forced_pullup(pb_latch[3], pullup_global_disable);
		ovr[3].value_ovr_en = spi_master | usart_b_tx_enable
			| (timers.cmp_en[2] & pb_dir[3]);
		if (usart_b_tx_enable)
		begin
			ovr[3].value_ovr_val = usart_b_tx_pin;
		end
		else if (spi_master)
		begin
			ovr[3].value_ovr_val = spi_a.master_out;
		end
		else
		begin
			ovr[3].value_ovr_val = timers.cmp_out[2];
		end

		// Bit 2, SPI select or 16-bit compare B
		ovr[2].dir_ovr_en = spi_slave;
		ovr[2].dir_ovr_val = 1'b0;
		ovr[2].pullup_ovr_en = spi_slave;
		ovr[2].pullup_ovr_val = forced_pullup(pb_latch[2], pullup_global_disable);
		ovr[2].value_ovr_en = timers.cmp_en[1] & pb_dir[2];
		ovr[2].value_ovr_val = timers.cmp_out[1];

		// Bit 1, 16-bit compare A
		ovr[1].value_ovr_en = timers.cmp_en[0] & pb_dir[1];
		ovr[1].value_ovr_val = timers.cmp_out[0];
	end

	////////////////////////////////////////////////////////////////////////
	// Generic override application, one instance per pin
	for (genvar g = 0; g < WIDTH; g++)
	begin : g_pin
		pbo_pin_ctl u_ctl
		(
			.ovr(ovr[g]),
			.dir(pb_dir[g]),
			.latch(pb_latch[g]),
			.pull_off(pullup_global_disable),
			.sleep_active(sleep_active),
			.oe(ctl_oe[g]),
			.value(ctl_out[g]),
			.pull_en(ctl_pull[g]),
			.din_en(ctl_din[g])
		);
	end

	// Pad control next values, one per pin from the override stage
	always_comb
	begin
		oe_d = ctl_oe;
		out_d = ctl_out;
		pullup_d = ctl_pull;
		din_en_d = ctl_din;
	end

	////////////////////////////////////////////////////////////////////////
	// Pin synchroniser, next values
	always_comb
	begin
		sync1_d = pad_in;
		sync2_d = sync1_q;
	end

	// Pad controls and synchroniser registers
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sync1_q <= pbo_pkg::PBO_SYNC_RST;
			sync2_q <= pbo_pkg::PBO_SYNC_RST;
			oe_q <= pbo_pkg::PBO_PAD_OE_RST;
			out_q <= pbo_pkg::PBO_PAD_OUT_RST;
			pullup_q <= pbo_pkg::PBO_PULLUP_RST;
			din_en_q <= pbo_pkg::PBO_DIN_EN_RST;
		end
		else
		begin
			sync1_q <= sync1_d;
			sync2_q <= sync2_d;
			oe_q <= oe_d;
			out_q <= out_d;
			pullup_q <= pullup_d;
			din_en_q <= din_en_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pad outputs; bit 0 carries the divided clock, also through reset
	always_comb
	begin
		pad_out = out_q;
		pad_oe = oe_q;
		pad_pullup = pullup_q;
		pad_din_en = din_en_q;
		if (clock_out_fuse)
		begin
			pad_out[pbo_pkg::PBO_BIT_CAPTURE] = divided_clock_out;
			pad_oe[pbo_pkg::PBO_BIT_CAPTURE] = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read-back, oscillator pins read as zero
	assign osc_pin = {osc7_use, osc6_use, {(WIDTH-2){1'b0}}};

	// Zero direction, latch and pin bits of oscillator pins
	always_comb
	begin
		pb_dir_rd = pb_dir & ~osc_pin;
		pb_latch_rd = pb_latch & ~osc_pin;
		pb_pinread = sync2_q & din_en_q & ~osc_pin;
	end

	////////////////////////////////////////////////////////////////////////
	// Inputs to the peripherals, all from the synchronised pins
	always_comb
	begin
		pin_change_src = sync2_q & din_en_q;
		periph_in.spi_a_clock_in = sync2_q[pbo_pkg::PBO_BIT_SCK];
		periph_in.usart_a_clock_in = sync2_q[pbo_pkg::PBO_BIT_SCK];
		periph_in.spi_a_master_in = sync2_q[pbo_pkg::PBO_BIT_MISO];
		periph_in.usart_b_rx_pin = sync2_q[pbo_pkg::PBO_BIT_MISO];
		periph_in.spi_a_slave_in = sync2_q[pbo_pkg::PBO_BIT_MOSI];
		// Select only matters to a slave engine
		periph_in.spi_a_select_active = spi_slave
			& ~sync2_q[pbo_pkg::PBO_BIT_SELECT];
		periph_in.timer16_capture_in = sync2_q[pbo_pkg::PBO_BIT_CAPTURE];
	end

endmodule : pbo_port_b_ovr

/* File: test/pbo_pad_model.sv */
`timescale 1ns/1ps
// Pads and outside world of port B
module pbo_pad_model
(
	input wire logic sys_clk,
	input wire logic [7:0] pad_out,
	input wire logic [7:0] pad_oe,
	input wire logic [7:0] pad_pullup,
	input wire logic [7:0] ext_val,
	input wire logic [7:0] ext_en,
	output logic [7:0] pad_in
);
	logic [7:0] float_q = 8'h55;
	// Undriven pads without pull-up wander each cycle
	always_ff @(posedge sys_clk)
		float_q <= ~float_q;
	// Own driver, then outside driver, then pull-up
	always_comb
		for (int i = 0; i < 8; i++)
			pad_in[i] = pad_oe[i] ? pad_out[i] : ext_en[i] ? ext_val[i] : pad_pullup[i] | float_q[i];
endmodule : pbo_pad_model

/* File: test/pbo_port_b_ovr_monitor.sv */
`timescale 1ns/1ps
// Checker on the port B override pins
module pbo_port_b_ovr_chk
#(
	parameter int WIDTH = 8
)
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] pad_in,
	input wire logic [WIDTH-1:0] pad_out,
	input wire logic [WIDTH-1:0] pad_oe,
	input wire logic [WIDTH-1:0] pad_pullup,
	input wire logic [WIDTH-1:0] pb_dir,
	input wire logic [WIDTH-1:0] pb_latch,
	input wire logic [WIDTH-1:0] pb_dir_rd,
	input wire logic [WIDTH-1:0] pb_latch_rd,
	input wire logic [WIDTH-1:0] pb_pinread,
	input wire logic pullup_global_disable,
	input wire pbo_pkg::pbo_spi_t spi_a,
	input wire logic usart_b_tx_enable,
	input wire logic usart_b_tx_pin,
	input wire pbo_pkg::pbo_tmr_t timers,
	input wire logic clock_out_fuse,
	input wire logic divided_clock_out,
	input wire logic async_timer_clocking,
	input wire pbo_pkg::pbo_periph_in_t periph_in,
	input wire logic internal_rc_selected
);
	logic slave;
	// Engine in slave role
	assign slave = spi_a.enable && !spi_a.master;
	default clocking dcb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////////////////////
	AST_OSC6_READ_ZERO: assert property (
		(internal_rc_selected || async_timer_clocking)
		|-> !pb_dir_rd[6] && !pb_latch_rd[6] && !pb_pinread[6])
		else $error("bit 6 readback not zero");
	AST_SLAVE_INPUTS: assert property (
		$past(rst_n && slave && !usart_b_tx_enable) |-> (pad_oe & 8'h2C) == 8'h00)
		else $error("slave pins not forced to input");
	AST_FORCED_PULLUP: assert property (
		$past(rst_n && slave)
		|-> pad_pullup[5] == $past(pb_latch[5] && !pullup_global_disable))
		else $error("forced input pull-up wrong");
	AST_MASTER_MISO_IN: assert property (
		$past(rst_n && spi_a.enable && spi_a.master) |-> !pad_oe[4])
		else $error("master-in pin driven");
	AST_TX_FORCES_OUT: assert property (
		$past(rst_n && usart_b_tx_enable && !spi_a.enable)
		|-> pad_oe[3] && pad_out[3] == $past(usart_b_tx_pin))
		else $error("transmit pin not driven");
	AST_CMP_NEEDS_DIR: assert property (
		$past(rst_n) |-> pad_oe[1] == $past(pb_dir[1]) && (!$past(pb_dir[1] &&
		timers.cmp_en[0]) || pad_out[1] == $past(timers.cmp_out[0])))
		else $error("compare output on bit 1 wrong");
	AST_CLOCK_OUT: assert property (
		disable iff (1'b0) clock_out_fuse |-> pad_oe[0] && pad_out[0] == divided_clock_out)
		else $error("divided clock not on bit 0");
	AST_CAPTURE_IN: assert property (
		$past(rst_n) && $past(rst_n, 2)
		|-> periph_in.timer16_capture_in == $past(pad_in[0], 2))
		else $error("capture input not following bit 0");
endmodule : pbo_port_b_ovr_chk

bind pbo_port_b_ovr pbo_port_b_ovr_chk #(.WIDTH(WIDTH)) i_chk (.*);

/* File: test/pbo_tb.sv */
`timescale 1ns/1ps
// Port B override bench
module testbench;
	logic sys_clk = 1'h0, rst_n = 1'h0;
	logic [7:0] pad_in, pad_out, pad_oe, pad_pullup, pad_din_en, pb_dir_rd, pb_latch_rd;
	logic [7:0] pb_pinread, pin_change_src, ext_val = 8'h00, ext_en = 8'h00;
	logic [7:0] pb_dir = 8'h00, pb_latch = 8'h00, pin_change_mask = 8'h00;
	logic pullup_global_disable = 1'h0, sleep_active = 1'h0, usart_a_sync_mode = 1'h0;
	logic usart_a_sync_clock = 1'h0, usart_b_rx_enable = 1'h0, usart_b_tx_enable = 1'h0;
	logic usart_b_tx_pin = 1'h0, clock_out_fuse = 1'h1, divided_clock_out = 1'h0;
	logic async_timer_clocking = 1'h0, pin_change_group_enable = 1'h0;
	logic internal_rc_selected, external_clock_selected;
	logic [3:0] clock_select_fuses = 4'h1;
	pbo_pkg::pbo_spi_t spi_a = 5'h00;
	pbo_pkg::pbo_tmr_t timers = 6'h00;
	pbo_pkg::pbo_periph_in_t periph_in;
	logic [7:0] spi_pins;
	assign spi_pins = {2'h0, periph_in.spi_a_clock_in, periph_in.usart_a_clock_in,
		periph_in.usart_b_rx_pin, periph_in.spi_a_master_in, periph_in.spi_a_slave_in,
		periph_in.spi_a_select_active};
	int miscompares = 0, num_checks = 0;
	// Design and its pads
	pbo_port_b_ovr i_dut (.*);
	pbo_pad_model i_pad (.*);
	always #5 sys_clk = ~sys_clk;
	////////////////////////////////////////////////////////////////
	task automatic chk(logic [7:0] got, logic [7:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic step(int n);
		repeat (n) @(negedge sys_clk);
	endtask : step
	task automatic tally_and_finish();
		$display("checks=%0d miscompares=%0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : tally_and_finish
	////////////////////////////////////////////////////////////////
	task automatic t_clock_out();
		repeat (10)
		begin
			step(1);
			divided_clock_out = ~divided_clock_out;
			#1;
			chk(pad_out & pad_oe & 8'h01, {7'h00, divided_clock_out});
		end
	endtask : t_clock_out
	task automatic t_osc();
		logic rc;
		pb_dir = 8'hFF;
		pb_latch = 8'hFF;
		for (int f = 0; f < 4; f++)
		begin
			step(1);
			clock_select_fuses = f[3:0];
			rc = (f == 2) || (f == 3);
			#1;
			chk({6'h00, internal_rc_selected, external_clock_selected}, {6'h00, rc, f == 0});
			chk(pb_dir_rd & pb_latch_rd & 8'h40, rc ? 8'h00 : 8'h40);
		end
		step(1);
		clock_select_fuses = 4'h1;
		async_timer_clocking = 1'h1;
		#1;
		chk(pb_dir_rd & pb_latch_rd & 8'hC0, 8'h00);
		step(1);
		async_timer_clocking = 1'h0;
	endtask : t_osc
	task automatic t_din();
		step(1);
		sleep_active = 1'h1;
		clock_select_fuses = 4'h0;
		pin_change_group_enable = 1'h1;
		pin_change_mask = 8'hC0;
		step(1);
		chk(pad_din_en & 8'hC0, 8'h80);
		sleep_active = 1'h0;
		pin_change_mask = 8'h00;
		clock_select_fuses = 4'h2;
		step(1);
		chk(pad_din_en & 8'hC0, 8'h80);
		clock_select_fuses = 4'h1;
		async_timer_clocking = 1'h1;
		step(1);
		chk(pad_din_en & 8'hC0, 8'h00);
		async_timer_clocking = 1'h0;
		pin_change_group_enable = 1'h0;
		step(1);
		chk(pad_din_en & 8'hC0, 8'hC0);
	endtask : t_din
	task automatic t_spi();
		step(1);
		spi_a = 5'h10;
		step(1);
		chk(pad_oe & 8'h2C, 8'h00);
		chk(pad_pullup & 8'h2C, 8'h2C);
		chk(pad_out & pad_oe & 8'h10, 8'h00);
		pullup_global_disable = 1'h1;
		step(1);
		chk(pad_pullup & 8'h2C, 8'h00);
		spi_a = 5'h18;
		step(1);
		chk(pad_oe & 8'h3C, 8'h2C);
		chk(pad_out & pad_oe & 8'h28, 8'h00);
		spi_a = 5'h10;
		pb_dir = 8'h00;
		ext_en = 8'h3C;
		ext_val = 8'h08;
		step(3);
		chk(spi_pins, 8'h03);
		ext_val = 8'h34;
		step(3);
		chk(spi_pins, 8'h3C);
		spi_a = 5'h00;
		ext_en = 8'h00;
		pullup_global_disable = 1'h0;
	endtask : t_spi
	task automatic t_usart();
		pb_dir = 8'hFF;
		usart_b_rx_enable = 1'h1;
		step(1);
		chk(pad_oe & 8'h10, 8'h00);
		usart_b_rx_enable = 1'h0;
		pb_dir = 8'h00;
		usart_b_tx_enable = 1'h1;
		usart_b_tx_pin = 1'h1;
		step(1);
		chk(pad_oe & pad_out & 8'h08, 8'h08);
		usart_b_tx_pin = 1'h0;
		step(1);
		chk((pad_oe ^ pad_out) & 8'h08, 8'h08);
		usart_b_tx_enable = 1'h0;
		usart_a_sync_mode = 1'h1;
		usart_a_sync_clock = 1'h1;
		pb_dir = 8'h20;
		step(1);
		chk(pad_oe & pad_out & 8'h20, 8'h20);
		pb_dir = 8'h00;
		step(1);
		chk(pad_oe & 8'h20, 8'h00);
		usart_a_sync_mode = 1'h0;
	endtask : t_usart
	task automatic t_cmp();
		timers = 6'h3D;
		step(1);
		chk(pad_oe & 8'h0E, 8'h00);
		pb_dir = 8'h0E;
		step(1);
		chk(pad_out & pad_oe & 8'h0E, 8'h0A);
		timers = 6'h3A;
		step(1);
		chk(pad_out & pad_oe & 8'h0E, 8'h04);
		timers = 6'h00;
		pb_dir = 8'h00;
	endtask : t_cmp
	task automatic t_capture();
		clock_out_fuse = 1'h0;
		sleep_active = 1'h1;
		pin_change_group_enable = 1'h1;
		pin_change_mask = 8'h01;
		ext_en = 8'h01;
		ext_val = 8'h01;
		step(3);
		chk({5'h00, pb_pinread[0], periph_in.timer16_capture_in, pin_change_src[0]}, 8'h07);
		ext_val = 8'h00;
		step(3);
		chk({5'h00, pb_pinread[0], periph_in.timer16_capture_in, pin_change_src[0]}, 8'h00);
		pin_change_mask = 8'h00;
		step(1);
		chk(pad_din_en & 8'h01, 8'h00);
	endtask : t_capture
	////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		t_clock_out();
		rst_n = 1'h1;
		t_osc();
		t_din();
		t_spi();
		t_usart();
		t_cmp();
		t_capture();
		tally_and_finish();
	end
endmodule : testbench
